// File: logic/mbp_top.sv
// match based pwm timer with ahb-lite register slave
// Operation
// R1: match 0 sets the period by clearing the count when the count equals it.
// R2: each enabled single-edge output goes high on the period match, a disabled one stays low.
// R3: a single-edge output n falls on match n, one extra match register per output.
// R4: a double-edge output n rises on match n-1 and falls on match n, anywhere in the cycle.
// R5: rising before falling gives a positive pulse, falling first gives a negative one.
// R6: seven matches give six single, three double, or a mix, on one shared period.
// R7: each match may keep counting, stop or reset the count, each with an optional event flag.
// R8: the count runs on the clock through the prescaler or on edges of a capture input.
// R9: new match values load only at the period match and only once software released them.
// R10: period and pulse width are any whole number of counts.
// R11: with pwm mode off the block is a plain 32-bit timer with a 32-bit prescaler.
// R12: a capture input transition copies the count into its capture register, optional flag.
`timescale 1ns/1ns
module mbp_top import mbp_pkg::*; (
    input wire logic clk, // system clock, 100 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size, word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready, always high
    output logic hresp, // always okay
    input wire logic [NCAP-1:0] cap_in, // capture inputs
    output logic [NOUT-1:0] pwm_out, // pwm outputs 1 to 6
    output logic event_pending // any event flag set
);
    // -------------------------------------------------------
    // state
    // -------------------------------------------------------
    typedef struct packed {
        // control and counting
        logic en;
        logic crst;
        logic pwm;
        logic [31:0] tc;
        logic [31:0] pr;
        logic [31:0] pc;
        // configuration
        logic [3:0] ctcr;
        logic [3*NMATCH-1:0] mcr;
        logic [3*NCAP-1:0] ccr;
        logic [NOUT-1:0] dbl;
        logic [NOUT-1:0] oen;
        logic [NMATCH-1:0] rel;
        logic [NMATCH+NCAP-1:0] flg;
        // match and capture values
        logic [NMATCH-1:0][31:0] shd;
        logic [NMATCH-1:0][31:0] act;
        logic [NCAP-1:0][31:0] cap;
        // bus data phase
        logic wpend;
        logic [7:0] waddr;
        logic [31:0] rdata;
    } mbp_state_t;

    mbp_state_t s;
    mbp_state_t next_s;

    logic [NCAP-1:0] cap_rise;
    logic [NCAP-1:0] cap_fall;
    logic [NMATCH-1:0] hit;
    logic [NOUT-1:0] set_evt;
    logic [NOUT-1:0] clr_evt;
    logic [NOUT-1:0] run;

    logic cnt_edge;
    logic tick;
    logic pre_wrap;
    logic do_rst;
    logic do_stop;

    logic accept;
    logic [2:0] widx;
    logic [2:0] ridx;
    logic timer_mode;
    logic rd_match;
    logic wr_match;


    // -------------------------------------------------------
    // capture input edges
    // -------------------------------------------------------
    // one edge detector per capture input
    genvar gc;
    generate
        for (gc = 0; gc < NCAP; gc++) begin : g_cap
            mbp_edge u_edge (
                .clk(clk),
                .rst_n(rst_n),
                .d(cap_in[gc]),
                .rise(cap_rise[gc]),
                .fall(cap_fall[gc])
            );
        end
    endgenerate

    // -------------------------------------------------------
    // count source and match detection
    // -------------------------------------------------------
    // edge kind and input picked by the count control
    always_comb begin
        logic sel;
        sel = s.ctcr[CTCR_SEL];
        case (s.ctcr[1:0])
            MODE_RISE: cnt_edge = cap_rise[sel]; // [R8]
            MODE_FALL: cnt_edge = cap_fall[sel]; // [R8]
            MODE_BOTH: cnt_edge = cap_rise[sel] | cap_fall[sel]; // [R8]
            default: cnt_edge = 1'b0;
        endcase
    end

    // timer mode counts prescaler wraps, count mode counts input edges
    assign timer_mode = (s.ctcr[1:0] == MODE_TIMER);
    assign pre_wrap = (s.pc == s.pr);
    assign tick = s.en & ~s.crst & (timer_mode ? pre_wrap : cnt_edge); // [R8] [R11]

    always_comb begin
        hit = '0;
        do_rst = 1'b0;
        do_stop = 1'b0;
        for (int i = 0; i < NMATCH; i++) begin
            hit[i] = tick & (s.tc == s.act[i]); // [R10]
            // pwm mode forces match 0 to restart the period
            if (hit[i] && (s.mcr[3*i+MCR_RST] || (i == 0 && s.pwm))) begin
                do_rst = 1'b1; // [R1] [R7]
            end
            if (hit[i] && s.mcr[3*i+MCR_STOP]) begin
                do_stop = 1'b1; // [R7]
            end
        end
    end

    // -------------------------------------------------------
    // pwm outputs
    // -------------------------------------------------------
    // output n+1 sits on bit n
    genvar go;
    generate
        for (go = 0; go < NOUT; go++) begin : g_out
            if (go == 0) begin : g_first
                assign set_evt[go] = hit[0]; // [R2] [R3]
            end else begin : g_rest
                assign set_evt[go] = s.dbl[go] ? hit[go] : hit[0]; // [R3] [R4] [R6]
            end
            // clear beats set inside the output flop
            assign clr_evt[go] = hit[go+1]; // [R3] [R4]
            assign run[go] = s.pwm & s.oen[go]; // [R2]
            mbp_pwm_out u_out (
                .clk(clk),
                .rst_n(rst_n),
                .run(run[go]),
                .set_evt(set_evt[go]),
                .clr_evt(clr_evt[go]),
                .q(pwm_out[go])
            );
        end
    endgenerate

    // -------------------------------------------------------
    // bus address phase
    // -------------------------------------------------------
    // zero wait states: hreadyout is tied high
    assign accept = hsel & hready & (htrans == HTRANS_NONSEQ);
    assign widx = mr_index(s.waddr);
    assign ridx = mr_index(haddr[7:0]);
    assign rd_match = (ridx != 3'(NMATCH));
    assign wr_match = (widx != 3'(NMATCH));

    // -------------------------------------------------------
    // next state
    // -------------------------------------------------------
    always_comb begin
        logic [NMATCH+NCAP-1:0] fset;
        logic [NMATCH+NCAP-1:0] fclr;
        fset = '0;
        fclr = '0;
        next_s = s;

        // --------
        // prescaler and counter
        // --------
        // counter reset holds both counts at zero
        if (s.crst) begin
            next_s.tc = RST_WORD;
            next_s.pc = RST_WORD;
        end else if (s.en) begin
            if (timer_mode) begin
                next_s.pc = pre_wrap ? RST_WORD : s.pc + 32'h00000001; // [R11]
            end
            if (tick) begin
                next_s.tc = do_rst ? RST_WORD : s.tc + 32'h00000001; // [R1] [R7]
            end
            // stop clears the enable, the count still takes this tick, then holds
            if (do_stop) begin
                next_s.en = 1'b0; // [R7]
            end
        end

        // --------
        // match event flags
        // --------
        // one event flag per match
        for (int i = 0; i < NMATCH; i++) begin
            fset[i] = hit[i] & s.mcr[3*i+MCR_INT]; // [R7]
        end

        // --------
        // capture
        // --------
        // capture takes the count before this cycle's increment
        for (int c = 0; c < NCAP; c++) begin
            if ((cap_rise[c] && s.ccr[3*c+CCR_RISE]) || (cap_fall[c] && s.ccr[3*c+CCR_FALL])) begin
                next_s.cap[c] = s.tc; // [R12]
                fset[FLG_CAP+c] = s.ccr[3*c+CCR_INT]; // [R12]
            end
        end

        // --------
        // match value transfer
        // --------
        // pwm off: match values follow the writes at once
        // release clears at the period match, a release write in that cycle wins
        if (!s.pwm) begin
            next_s.act = s.shd; // [R11]
        end else if (hit[0]) begin
            for (int i = 0; i < NMATCH; i++) begin
                if (s.rel[i]) begin
                    next_s.act[i] = s.shd[i]; // [R9]
                end
            end
            next_s.rel = '0; // [R9]
        end

        // --------
        // read data for the next data phase
        // --------
        // no forwarding: a read right after a write sees the old value
        next_s.wpend = accept & hwrite;
        if (accept && hwrite) begin
            next_s.waddr = haddr[7:0];
        end
        if (accept && !hwrite) begin
            next_s.rdata = RST_WORD;
            // match reads return the pending value
            if (rd_match) begin
                next_s.rdata = s.shd[ridx];
            end else begin
                case (haddr[7:0])
                    A_CTRL: next_s.rdata = {29'h00000000, s.pwm, s.crst, s.en};
                    A_COUNT: next_s.rdata = s.tc;
                    A_PRE_LIM: next_s.rdata = s.pr;
                    A_PRE_CNT: next_s.rdata = s.pc;
                    A_CNT_CTL: next_s.rdata = {28'h0000000, s.ctcr};
                    A_MATCH_CTL: next_s.rdata = {11'h000, s.mcr};
                    A_CAP_CTL: next_s.rdata = {26'h0000000, s.ccr};
                    A_PWM_CTL: next_s.rdata = {18'h00000, s.oen, 2'h0, s.dbl[NOUT-1:1], 1'b0};
                    A_RELEASE: next_s.rdata = {25'h0000000, s.rel};
                    A_FLAGS: next_s.rdata = {23'h000000, s.flg};
                    A_CAP0: next_s.rdata = s.cap[0];
                    A_CAP0 + 8'h04: next_s.rdata = s.cap[1];
                    default: next_s.rdata = RST_WORD;
                endcase
            end
        end

        // --------
        // register writes in the data phase
        // --------
        if (s.wpend) begin
            if (wr_match) begin
                next_s.shd[widx] = hwdata; // [R9]
            end else begin
                case (s.waddr)
                    A_CTRL: begin
                        // enable, counter reset and pwm mode
                        next_s.en = hwdata[CTRL_EN];
                        next_s.crst = hwdata[CTRL_RST];
                        next_s.pwm = hwdata[CTRL_PWM];
                    end
                    A_COUNT: next_s.tc = hwdata;
                    A_PRE_LIM: next_s.pr = hwdata; // [R11]
                    A_PRE_CNT: next_s.pc = hwdata;
                    A_CNT_CTL: next_s.ctcr = hwdata[3:0]; // [R8]
                    A_MATCH_CTL: next_s.mcr = hwdata[3*NMATCH-1:0]; // [R7]
                    A_CAP_CTL: next_s.ccr = hwdata[3*NCAP-1:0]; // [R12]
                    A_PWM_CTL: begin
                        next_s.dbl = {hwdata[PCR_DBL+NOUT-1:PCR_DBL+1], 1'b0}; // [R6]
                        next_s.oen = hwdata[PCR_OEN+NOUT-1:PCR_OEN]; // [R2]
                    end
                    A_RELEASE: next_s.rel = hwdata[NMATCH-1:0]; // [R9]
                    // flags: write one to clear
                    A_FLAGS: fclr = hwdata[NMATCH+NCAP-1:0];
                    default: begin
                        // unmapped writes are dropped
                    end
                endcase
            end
        end

        // --------
        // set wins over a clear in the same cycle
        // --------
        next_s.flg = (s.flg & ~fclr) | fset;
    end

    // -------------------------------------------------------
    // registers
    // -------------------------------------------------------
    // one register stage for the whole state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // -------------------------------------------------------
    // outputs
    // -------------------------------------------------------
    assign hrdata = s.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign event_pending = |s.flg;
endmodule : mbp_top

// File: shared/mbp_pkg.sv
// constants and decode helpers for the match based pwm timer
package mbp_pkg;
    // -------------------------------------------------------
    // sizes
    // -------------------------------------------------------
    localparam int NMATCH = 7;
    localparam int NCAP = 2;
    localparam int NOUT = 6;
    // -------------------------------------------------------
    // register byte offsets
    // -------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_COUNT = 8'h04;
    localparam logic [7:0] A_PRE_LIM = 8'h08;
    localparam logic [7:0] A_PRE_CNT = 8'h0C;
    localparam logic [7:0] A_CNT_CTL = 8'h10;
    localparam logic [7:0] A_MATCH_CTL = 8'h14;
    localparam logic [7:0] A_CAP_CTL = 8'h18;
    localparam logic [7:0] A_PWM_CTL = 8'h1C;
    localparam logic [7:0] A_RELEASE = 8'h20;
    localparam logic [7:0] A_FLAGS = 8'h24;
    localparam logic [7:0] A_MATCH0 = 8'h28;
    localparam logic [7:0] A_CAP0 = 8'h44;
    // -------------------------------------------------------
    // field positions
    // -------------------------------------------------------
    localparam int CTRL_EN = 0;
    localparam int CTRL_RST = 1;
    localparam int CTRL_PWM = 2;
    localparam int MCR_INT = 0;
    localparam int MCR_RST = 1;
    localparam int MCR_STOP = 2;
    localparam int CCR_RISE = 0;
    localparam int CCR_FALL = 1;
    localparam int CCR_INT = 2;
    localparam int PCR_DBL = 0;
    localparam int PCR_OEN = 8;
    localparam int CTCR_SEL = 2;
    localparam int FLG_CAP = 7;
    // -------------------------------------------------------
    // counting modes and reset values
    // -------------------------------------------------------
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_RISE = 2'h1;
    localparam logic [1:0] MODE_FALL = 2'h2;
    localparam logic [1:0] MODE_BOTH = 2'h3;
    localparam logic [31:0] RST_WORD = 32'h00000000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // match register index from a byte offset, NMATCH when none
    function automatic logic [2:0] mr_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - A_MATCH0;
        if (a >= A_MATCH0 && a < A_CAP0 && d[1:0] == 2'h0) begin
            mr_index = d[4:2];
        end else begin
            mr_index = 3'(NMATCH);
        end
    endfunction : mr_index
endpackage : mbp_pkg

// File: logic/mbp_edge.sv
// transition detector for one capture input
`timescale 1ns/1ns
module mbp_edge (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic d, // capture input level
    output logic rise, // high for the cycle of a rising edge
    output logic fall // high for the cycle of a falling edge
);
    typedef struct packed {
        logic prev;
    } mbp_edge_t;

    mbp_edge_t s;
    mbp_edge_t next_s;

    always_comb begin
        next_s = s;
        next_s.prev = d;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rise = d & ~s.prev;
    assign fall = ~d & s.prev;
endmodule : mbp_edge

// File: logic/mbp_pwm_out.sv
// one pwm output flip-flop, set and cleared by match events
`timescale 1ns/1ns
module mbp_pwm_out (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic run, // pwm mode on and output enabled
    input wire logic set_evt, // match that raises the output
    input wire logic clr_evt, // match that lowers the output
    output logic q // pwm output level
);
    typedef struct packed {
        logic q;
    } mbp_out_t;

    mbp_out_t s;
    mbp_out_t next_s;

    always_comb begin
        next_s = s;
        if (!run) begin
            next_s.q = 1'b0;
        end else if (clr_evt) begin
            next_s.q = 1'b0; // [R4] [R5]
        end else if (set_evt) begin
            next_s.q = 1'b1; // [R2] [R4]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.q;
endmodule : mbp_pwm_out

// File: dv/mbp_chk.sv
// port checker for the match based pwm timer
`timescale 1ns/1ns
module mbp_chk import mbp_pkg::*; (
    input wire logic clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic [2:0] hsize, // size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    input wire logic [31:0] hrdata, // read data
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic [NCAP-1:0] cap_in, // capture inputs
    input wire logic [NOUT-1:0] pwm_out, // pwm outputs
    input wire logic event_pending // event level
);
    logic take;
    logic wr_q;
    logic pwm_on;
    logic [7:0] a_q;
    logic [13:0] pcr;
    logic [2:0] ccr;
    logic [2:0] fl_cnt;
    logic [NOUT-1:0] gate;
    assign take = hsel && hready && htrans == HTRANS_NONSEQ;
    assign gate = pwm_on ? pcr[13:8] : '0;
    // ---------------------------------------
    // shadow of written control fields
    // ---------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= 1'b0;
            a_q <= 8'h00;
            pcr <= 14'h0000;
            ccr <= 3'h0;
            pwm_on <= 1'b0;
            fl_cnt <= 3'h7;
        end else begin
            wr_q <= take && hwrite;
            if (take) begin
                a_q <= haddr[7:0];
            end
            fl_cnt <= (wr_q && a_q == A_FLAGS) ? 3'h0 : ((fl_cnt == 3'h7) ? fl_cnt : fl_cnt + 3'h1);
            if (wr_q && a_q == A_PWM_CTL) begin
                pcr <= hwdata[13:0] & 14'h3F3E;
            end
            if (wr_q && a_q == A_CTRL) begin
                pwm_on <= hwdata[CTRL_PWM];
            end
            if (wr_q && a_q == A_CAP_CTL) begin
                ccr <= hwdata[2:0];
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("slave ready low");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_unmapped_zero: assert property (take && !hwrite && haddr[7:0] > 8'h48 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without read");
    a_pcr_readback: assert property (take && !hwrite && haddr[7:0] == A_PWM_CTL
        |=> hrdata == {18'h0, $past(pcr)})
        else $error("output control readback wrong");
    a_out_gated: assert property ((pwm_out & ~(gate | $past(gate))) == '0)
        else $error("disabled output high");
    a_flag_clear: assert property ($fell(event_pending) |-> fl_cnt < 3'h4)
        else $error("event fell without flag clear");
    a_cap_event: assert property (ccr[0] && ccr[2] && $rose(cap_in[0]) |-> ##[1:4] event_pending)
        else $error("capture event missing");
endmodule : mbp_chk

bind mbp_top mbp_chk i_chk (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cap_in(cap_in), .pwm_out(pwm_out), .event_pending(event_pending));

// File: dv/mbp_load.sv
// load model measuring the last pulse widths on every pwm pin
`timescale 1ns/1ns
module mbp_load import mbp_pkg::*; (
    input wire logic clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic [NOUT-1:0] pwm_out, // pwm pins
    output logic [15:0] hi_w [NOUT], // last high width in clocks
    output logic [15:0] lo_w [NOUT] // last low width in clocks
);
    logic [15:0] run [NOUT];
    logic [NOUT-1:0] prev;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= '0;
            for (int i = 0; i < NOUT; i++) begin
                run[i] <= 16'h0001;
                hi_w[i] <= 16'h0000;
                lo_w[i] <= 16'h0000;
            end
        end else begin
            prev <= pwm_out;
            for (int i = 0; i < NOUT; i++) begin
                if (pwm_out[i] != prev[i]) begin
                    run[i] <= 16'h0001;
                    if (pwm_out[i]) begin
                        lo_w[i] <= run[i];
                    end else begin
                        hi_w[i] <= run[i];
                    end
                end else begin
                    run[i] <= run[i] + 16'h0001;
                end
            end
        end
    end
endmodule : mbp_load

// File: dv/testbench.sv
// self-checking testbench for the match based pwm timer
`timescale 1ns/1ns
module testbench;
    import mbp_pkg::*;
    logic clk, hrdy, hresp, evp;
    logic rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0, cap = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic [NOUT-1:0] pwm;
    logic [15:0] hi_w [NOUT];
    logic [15:0] lo_w [NOUT];
    int error_cnt = 0, checks_done = 0;
    mbp_top i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
        .cap_in(cap), .pwm_out(pwm), .event_pending(evp));
    mbp_load i_load (.clk(clk), .rst_n(rst_n), .pwm_out(pwm), .hi_w(hi_w), .lo_w(lo_w));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ---------------------------------------
    // shared tasks
    // ---------------------------------------
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hrdy !== 1'b1 && n < 16);
        if (hrdy !== 1'b1) begin
            error_cnt++;
            stop_test();
        end
    endtask : wait_rdy
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : bus
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk
    task automatic wchk(input int i, input logic [15:0] h, input logic [15:0] l);
        chk({16'h0, hi_w[i]}, {16'h0, h});
        chk({16'h0, lo_w[i]}, {16'h0, l});
    endtask : wchk
    task automatic pulse(input int c);
        cap[c] <= 1'b1;
        repeat (3) @(posedge clk);
        cap[c] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse
    // ---------------------------------------
    // scenarios
    // ---------------------------------------
    task automatic t_reset();
        chk({26'h0, pwm}, 32'h0);
        rchk(A_CTRL, RST_WORD);
        rchk(A_FLAGS, RST_WORD);
        bus(1'b1, 8'h50, 32'hFFFFFFFF);
        rchk(8'h50, 32'h0);
        bus(1'b1, A_PWM_CTL, 32'hFFFFFFFF);
        rchk(A_PWM_CTL, 32'h00003F3E);
        bus(1'b1, A_PWM_CTL, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_period();
        int n;
        bus(1'b1, A_PRE_LIM, 32'h1);
        bus(1'b1, A_MATCH0, 32'h3);
        bus(1'b1, A_MATCH_CTL, 32'h3);
        bus(1'b1, A_CTRL, 32'h1);
        repeat (5) begin
            bus(1'b0, A_COUNT, 32'h0);
            chk({31'h0, rd > 32'h3}, 32'h0);
        end
        bus(1'b0, A_FLAGS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        bus(1'b1, A_CTRL, 32'h2);
        bus(1'b1, A_FLAGS, 32'h1FF);
        repeat (3) @(posedge clk);
        chk({31'h0, evp}, 32'h0);
        bus(1'b1, A_PRE_LIM, 32'h4);
        bus(1'b1, A_MATCH0 + 8'h04, 32'h14);
        bus(1'b1, A_MATCH_CTL, 32'h28);
        bus(1'b1, A_CTRL, 32'h1);
        n = 0;
        while (evp !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, n inside {[100:112]}}, 32'h1);
        rchk(A_CTRL, 32'h0);
        bus(1'b0, A_FLAGS, 32'h0);
        chk(rd & 32'h7F, 32'h2);
        $display("test period done");
    endtask : t_period
    task automatic t_pwm();
        bus(1'b1, A_CTRL, 32'h2);
        bus(1'b1, A_PRE_LIM, 32'h0);
        bus(1'b1, A_MATCH_CTL, 32'h0);
        bus(1'b1, A_MATCH0, 32'h9);
        bus(1'b1, A_MATCH0 + 8'h08, 32'h4);
        bus(1'b1, A_MATCH0 + 8'h10, 32'h7);
        bus(1'b1, A_PWM_CTL, 32'h00000A00);
        bus(1'b1, A_CTRL, 32'h5);
        repeat (40) @(posedge clk);
        wchk(1, 16'h5, 16'h5);
        wchk(3, 16'h8, 16'h2);
        wchk(0, 16'h0, 16'h0);
        bus(1'b1, A_MATCH0 + 8'h08, 32'h6);
        repeat (40) @(posedge clk);
        wchk(1, 16'h5, 16'h5);
        bus(1'b1, A_RELEASE, 32'h4);
        repeat (40) @(posedge clk);
        wchk(1, 16'h7, 16'h3);
        bus(1'b1, A_CTRL, 32'h2);
        bus(1'b1, A_MATCH0 + 8'h08, 32'h2);
        bus(1'b1, A_MATCH0 + 8'h0C, 32'h6);
        bus(1'b1, A_PWM_CTL, 32'h00000604);
        bus(1'b1, A_CTRL, 32'h5);
        repeat (40) @(posedge clk);
        wchk(2, 16'h4, 16'h6);
        wchk(1, 16'h3, 16'h7);
        bus(1'b1, A_MATCH0 + 8'h08, 32'h7);
        bus(1'b1, A_MATCH0 + 8'h0C, 32'h3);
        bus(1'b1, A_RELEASE, 32'h0C);
        repeat (40) @(posedge clk);
        wchk(2, 16'h6, 16'h4);
        $display("test pwm done");
    endtask : t_pwm
    task automatic t_count();
        bus(1'b1, A_CAP_CTL, 32'h5);
        bus(1'b1, A_FLAGS, 32'h1FF);
        for (int m = 1; m < 4; m++) begin
            bus(1'b1, A_CTRL, 32'h2);
            bus(1'b1, A_CNT_CTL, 32'(m) | 32'h4);
            bus(1'b1, A_CTRL, 32'h1);
            pulse(1);
            pulse(1);
            rchk(A_COUNT, (m == 3) ? 32'h4 : 32'h2);
        end
        pulse(0);
        rchk(A_CAP0, 32'h4);
        bus(1'b0, A_FLAGS, 32'h0);
        chk(rd & 32'h180, 32'h80);
        $display("test count done");
    endtask : t_count
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_period();
        t_pwm();
        t_count();
        stop_test();
    end
    initial begin
        #900000;
        error_cnt++;
        stop_test();
    end
endmodule : testbench
